// ==== rtl/btc_consts.svh ====
// constants for the branch target cache and prefetch engine
`ifndef BTC_CONSTS_SVH
`define BTC_CONSTS_SVH
// ============================================================
// register map (byte offsets on the plain register port)
`define ADDR_CACHE_CONTROL 4'h0
`define ADDR_CACHE_TUNING 4'h1
`define ADDR_FLASH_CONTROL 4'h2
`define ADDR_CACHE_STATUS 4'h3
// cache_control_reg fields
`define CCTL_WRITE_PERMIT 7
`define CCTL_READ_ENABLE 6
`define CCTL_PREFETCH_ON 5
`define CCTL_EMPTY_CMD 4
`define CCTL_RESET 8'hE6
// cache_tuning_reg fields
`define CTUN_REPL_SELECT 3
`define CTUN_RESET 8'h00
// flash_memory_control fields: read strobe length at bit 4
`define FLCTL_STROBE_LEN 4
`define FLCTL_RESET 8'h00
// lfsr seed and taps (8-bit maximal)
`define LFSR_SEED 8'hA5
`define LFSR_TAPS 8'hB8
// ============================================================
// timing
`define CLK_MHZ 50
`define SLOW_CLK_MHZ 25
`define STROBE_LONG_CYCLES 2
`define STROBE_SHORT_CYCLES 1
`endif

// ==== rtl/btc_pkg.sv ====
// types shared by the branch target cache
package btc_pkg;
  typedef struct packed {
    logic valid;
    logic [12:0] tag;
  } tag_entry_type;
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_DONE} fetch_state_type;
endpackage

// ==== rtl/branch_target_cache_prefetch.sv ====
// branch target cache with linear prefetch entry in front of program flash
`timescale 1ns/1ps
`include "btc_consts.svh"
// How it works
// [RQ1] thirty-two four-byte slots plus four-byte prefetch
// [RQ2] prefetch reads flash four bytes at time
// [RQ3] hit returns cached data same cycle; the registered answer comes one edge after the request
// [RQ4] miss stalls core at most four cycles
// [RQ5] miss data written into cache when permitted
// [RQ6] slots word aligned, tag upper thirteen bits
// [RQ7] only valid tags may match
// [RQ8] separate linear tag and slot for prefetch
// [RQ9] compare all valid tags, linear one included
// [RQ10] stall when address is group being read
// [RQ11] no match abandons prefetch, starts new one
// [RQ12] fill slot chosen by policy, mark valid
// [RQ13] select bit: zero rebound, one random
// [RQ14] rebound walks up then down, repeating
// [RQ15] empty command invalidates whole cache
// [RQ16] flash strobe one or two clocks long
// [RQ17] reset strobe length safe up to 25MHz
// [RQ18] flash active only while strobe asserted
// [RQ19] software slows clock before changing strobe
// [RQ20] prefetch_on zero disables prefetch engine
// [RQ21] flash write or erase invalidates matching entries
// [RQ22] empty command self clears, drops linear entry
// [RQ23] random victim from free running lfsr
module branch_target_cache_prefetch #(
  parameter int ENTRIES = 32,
  parameter int ADDR_W = 15
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // core fetch port
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  output logic [31:0] fetch_data,
  output logic fetch_valid,
  output logic fetch_stall,
  // flash array
  output logic flash_strobe,
  output logic [ADDR_W-3:0] flash_word_addr,
  input wire logic [31:0] flash_rdata,
  // flash program/erase notice
  input wire logic flash_mod,
  input wire logic [ADDR_W-1:0] flash_mod_addr,
  input wire logic flash_mod_page,
  input wire logic [ADDR_W-1:0] flash_page_mask
);
  localparam int IDX_W = $clog2(ENTRIES);
  localparam int TAG_W = ADDR_W - 2;
  localparam int STROBE_CYC_MAX = `STROBE_LONG_CYCLES;
  localparam int STROBE_CYC_MIN = `STROBE_SHORT_CYCLES;

  // refuse geometries that the tag width and power-of-two victim index cannot serve
  if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES || TAG_W != 13)
  begin : g_geometry_check
    $error("unsupported cache geometry");
  end

  // ============================================================
  // registers
  logic [7:0] cache_control_reg_r;
  logic [7:0] cache_tuning_reg_r;
  logic [7:0] flash_memory_control_r;
  wire cache_write_permit = cache_control_reg_r[`CCTL_WRITE_PERMIT];
  wire cache_read_en = cache_control_reg_r[`CCTL_READ_ENABLE];
  wire prefetch_on = cache_control_reg_r[`CCTL_PREFETCH_ON];
  wire replacement_select = cache_tuning_reg_r[`CTUN_REPL_SELECT];
  wire read_strobe_length = flash_memory_control_r[`FLCTL_STROBE_LEN];
  wire empty_cmd = reg_write && reg_addr == `ADDR_CACHE_CONTROL
    && reg_wdata[`CCTL_EMPTY_CMD]; // [RQ15]

  // register writes; empty command bit never stored so it reads zero
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cache_control_reg_r <= `CCTL_RESET;
      cache_tuning_reg_r <= `CTUN_RESET;
      flash_memory_control_r <= `FLCTL_RESET; // [RQ17]
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        `ADDR_CACHE_CONTROL: cache_control_reg_r <= reg_wdata & ~(8'h01 << `CCTL_EMPTY_CMD); // [RQ22]
        `ADDR_CACHE_TUNING: cache_tuning_reg_r <= reg_wdata;
        `ADDR_FLASH_CONTROL: flash_memory_control_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ============================================================
  // tag store and slots
  btc_pkg::tag_entry_type tags_r [ENTRIES]; // [RQ1] [RQ6]
  logic [31:0] slots_r [ENTRIES];
  btc_pkg::tag_entry_type lin_tag_r; // [RQ8]
  logic [31:0] lin_slot_r;
  logic [IDX_W-1:0] victim_r;
  logic rebound_down_r;
  logic [7:0] lfsr_r;

  // word tag of a byte address
  function automatic logic [12:0] tag_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // true when tag matches a flash change (byte or page)
  function automatic logic hit_mod(input logic [12:0] t);
    logic [ADDR_W-1:0] base;
    base = {t, 2'b00};
    if (flash_mod_page)
      return (base & flash_page_mask) == (flash_mod_addr & flash_page_mask);
    return t == tag_of(flash_mod_addr);
  endfunction

  // ============================================================
  // lookup
  wire [12:0] req_tag = tag_of(fetch_addr);
  logic cache_hit;
  logic [31:0] cache_hit_data;
  always_comb
  begin
    cache_hit = 1'b0;
    cache_hit_data = 32'h0000_0000;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (tags_r[i].valid && tags_r[i].tag == req_tag && cache_read_en) // [RQ7] [RQ9]
      begin
        cache_hit = 1'b1;
        cache_hit_data = slots_r[i];
      end
    end
  end
  wire lin_hit = lin_tag_r.valid && lin_tag_r.tag == req_tag; // [RQ9]

  // ============================================================
  // fetch engine
  btc_pkg::fetch_state_type state_r;
  logic [12:0] busy_tag_r;
  logic [1:0] strobe_cnt_r;
  logic [2:0] stall_cnt_r;
  logic pending_r;
  wire in_flight = state_r == btc_pkg::ST_STROBE;
  wire same_group = in_flight && busy_tag_r == req_tag; // [RQ10]
  wire miss = fetch_req && !cache_hit && !lin_hit && !same_group;
  wire [1:0] strobe_len = read_strobe_length ? 2'(STROBE_CYC_MAX) : 2'(STROBE_CYC_MIN);
  wire strobe_end = in_flight && strobe_cnt_r == strobe_len - 2'd1;
  // the next word is read only once the core takes the linear word, so a
  // request still held after its answer finds that word in place
  wire lin_adv = prefetch_on && fetch_req && lin_hit && !in_flight; // [RQ20]

  // engine state: a miss restarts even mid-read, abandoning the old word
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= btc_pkg::ST_IDLE;
      busy_tag_r <= 13'h0000;
      strobe_cnt_r <= 2'h0;
      pending_r <= 1'b0;
    end
    else if (miss)
    begin
      state_r <= btc_pkg::ST_STROBE; // [RQ11]
      busy_tag_r <= req_tag;
      strobe_cnt_r <= 2'h0;
      pending_r <= 1'b1;
    end
    else if (lin_adv)
    begin
      state_r <= btc_pkg::ST_STROBE;
      busy_tag_r <= lin_tag_r.tag + 13'd1; // [RQ2]
      strobe_cnt_r <= 2'h0;
    end
    else if (in_flight && !strobe_end)
      strobe_cnt_r <= strobe_cnt_r + 2'd1; // [RQ16]
    else if (strobe_end)
    begin
      pending_r <= 1'b0;
      state_r <= btc_pkg::ST_IDLE;
    end
  end

  // flash strobe only during a read; array idles otherwise
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_strobe <= 1'b0;
      flash_word_addr <= '0;
    end
    else
    begin
      flash_strobe <= miss || lin_adv || (in_flight && !strobe_end); // [RQ18]
      flash_word_addr <= miss ? req_tag
        : (lin_adv ? lin_tag_r.tag + 13'd1 : busy_tag_r);
    end
  end

  // stall counter; with two-clock strobe the wait stays within four cycles
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      stall_cnt_r <= 3'h0;
    else if (miss)
      stall_cnt_r <= 3'h1; // [RQ4]
    else if (in_flight && pending_r)
      stall_cnt_r <= stall_cnt_r + 3'h1;
  end

  // linear entry follows each completed word
  // a miss at the last strobe cycle cancels the capture, so abandoned words never land
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lin_tag_r <= '0;
      lin_slot_r <= 32'h0000_0000;
    end
    else if (empty_cmd)
      lin_tag_r.valid <= 1'b0; // [RQ22]
    else if (strobe_end && !miss)
    begin
      lin_tag_r <= '{valid: 1'b1, tag: busy_tag_r};
      lin_slot_r <= flash_rdata;
    end
    else if (flash_mod && hit_mod(lin_tag_r.tag))
      lin_tag_r.valid <= 1'b0; // [RQ21]
  end

  // ============================================================
  // fill of the branch target slots
  wire fill = strobe_end && !miss && pending_r && cache_write_permit; // [RQ5]
  integer k;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (k = 0; k < ENTRIES; k++)
      begin
        tags_r[k] <= '0;
        slots_r[k] <= 32'h0000_0000;
      end
    end
    else
    begin
      for (k = 0; k < ENTRIES; k++)
      begin
        if (empty_cmd)
          tags_r[k].valid <= 1'b0; // [RQ15]
        else if (fill && victim_r == IDX_W'(k))
        begin
          tags_r[k] <= '{valid: 1'b1, tag: busy_tag_r}; // [RQ12]
          slots_r[k] <= flash_rdata;
        end
        else if (flash_mod && hit_mod(tags_r[k].tag))
          tags_r[k].valid <= 1'b0; // [RQ21]
      end
    end
  end

  // free-running lfsr for the random policy
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lfsr_r <= `LFSR_SEED;
    else
      lfsr_r <= {lfsr_r[6:0], ^(lfsr_r & `LFSR_TAPS)}; // [RQ23]
  end

  // victim pointer: rebound bounces between ends, random takes lfsr bits
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      victim_r <= '0;
      rebound_down_r <= 1'b0;
    end
    else if (replacement_select)
      victim_r <= lfsr_r[IDX_W-1:0]; // [RQ13] [RQ23]
    else if (fill)
    begin
      if (!rebound_down_r && victim_r == IDX_W'(ENTRIES - 1))
      begin
        rebound_down_r <= 1'b1;
        victim_r <= victim_r - 1'b1; // [RQ14]
      end
      else if (rebound_down_r && victim_r == '0)
      begin
        rebound_down_r <= 1'b0;
        victim_r <= victim_r + 1'b1;
      end
      else
        victim_r <= rebound_down_r ? victim_r - 1'b1 : victim_r + 1'b1; // [RQ13]
    end
  end

  // ============================================================
  // core answer, registered: data and valid one edge after a hitting request
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_data <= 32'h0000_0000;
      fetch_valid <= 1'b0;
      fetch_stall <= 1'b0;
    end
    else
    begin
      fetch_valid <= fetch_req && (cache_hit || lin_hit); // [RQ3]
      fetch_data <= cache_hit ? cache_hit_data : lin_slot_r;
      fetch_stall <= fetch_req && !cache_hit && !lin_hit; // [RQ10]
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      unique case (reg_addr)
        `ADDR_CACHE_CONTROL: reg_rdata <= cache_control_reg_r;
        `ADDR_CACHE_TUNING: reg_rdata <= cache_tuning_reg_r;
        `ADDR_FLASH_CONTROL: reg_rdata <= flash_memory_control_r;
        `ADDR_CACHE_STATUS: reg_rdata <= {in_flight, lin_tag_r.valid, 3'(stall_cnt_r), 3'h0};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule // branch_target_cache_prefetch

// ==== sim/flash_model.sv ====
// program flash stand-in for the cache's read strobe
`timescale 1ns/1ps
module flash_model (
  // clock
  input wire logic core_clk,
  // array side
  input wire logic flash_strobe,
  input wire logic [12:0] flash_word_addr,
  output logic [31:0] flash_rdata
);
  logic [31:0] junk_r = 32'h5A5A_5A5A;
  // junk flips every clock so stale words never pass as a read
  always_ff @(posedge core_clk)
  begin
    junk_r <= ~junk_r;
  end
  // array answers only while strobed
  assign flash_rdata = flash_strobe ? {6'h2A, flash_word_addr, flash_word_addr} : junk_r;
endmodule // flash_model

// ==== sim/btc_monitor.sv ====
// checker for the fetch and register ports of the cache
`timescale 1ns/1ps
module btc_monitor #(
  parameter int ADDR_W = 15
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // fetch and flash
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic fetch_stall,
  input wire logic flash_strobe,
  input wire logic [ADDR_W-3:0] flash_word_addr
);
  logic [ADDR_W-3:0] req_word;
  assign req_word = fetch_addr[ADDR_W-1:2];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ============================================================
  // fetch side
  chk_miss_bound: assert property ($rose(fetch_stall) |-> ##[1:4] fetch_valid)
    else $error("miss not served in time");
  chk_miss_strobe: assert property ($rose(fetch_stall) |-> flash_strobe)
    else $error("miss without flash read");
  chk_miss_word: assert property ($rose(fetch_stall) |-> flash_word_addr == $past(req_word))
    else $error("flash word differs from request");
  chk_valid_cause: assert property (fetch_valid |-> $past(fetch_req))
    else $error("answer without request");
  chk_stall_cause: assert property ($rose(fetch_stall) |-> $past(fetch_req))
    else $error("stall without request");
  chk_valid_stall: assert property (fetch_valid |-> !fetch_stall)
    else $error("answer while stalled");
  // ============================================================
  // register side
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_empty_clear: assert property (reg_read && reg_addr == 4'h0 |=> !reg_rdata[4])
    else $error("empty command reads back set");
  cov_miss: cover property ($rose(fetch_stall));
  cov_hit_run: cover property (fetch_valid && !$past(fetch_stall));
  cov_long_strobe: cover property (flash_strobe [*2]);
endmodule // btc_monitor
bind branch_target_cache_prefetch btc_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .fetch_valid(fetch_valid), .fetch_stall(fetch_stall), .flash_strobe(flash_strobe),
  .flash_word_addr(flash_word_addr));

// ==== sim/branch_target_cache_prefetch_tb.sv ====
// self-checking bench for the branch target cache
`timescale 1ns/1ps
module branch_target_cache_prefetch_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic fetch_req = 1'b0;
  logic [14:0] fetch_addr = 15'h0000;
  logic [31:0] fetch_data, flash_rdata;
  logic fetch_valid, fetch_stall, flash_strobe, f_miss;
  logic [12:0] flash_word_addr;
  logic flash_mod = 1'b0;
  logic [14:0] flash_mod_addr = 15'h0000;
  logic flash_mod_page = 1'b0;
  logic [14:0] flash_page_mask = 15'h0000;
  int n_fail = 0;
  int num_checks = 0;
  int f_lat, f_str;
  branch_target_cache_prefetch dut (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid), .fetch_stall(fetch_stall),
    .flash_strobe(flash_strobe), .flash_word_addr(flash_word_addr),
    .flash_rdata(flash_rdata), .flash_mod(flash_mod), .flash_mod_addr(flash_mod_addr),
    .flash_mod_page(flash_mod_page), .flash_page_mask(flash_page_mask));
  flash_model u_flash (.core_clk(core_clk), .flash_strobe(flash_strobe),
    .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    check(32'(reg_rdata), 32'(exp));
  endtask
  // request held until answered; strobes counted on the requested word only
  task automatic fetch(input logic [14:0] a);
    @(posedge core_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    f_str = 0;
    f_miss = 1'b0;
    for (f_lat = 1; f_lat < 10; f_lat++)
    begin
      @(posedge core_clk);
      #1;
      if (fetch_stall === 1'b1) f_miss = 1'b1;
      if (flash_strobe === 1'b1 && flash_word_addr === a[14:2]) f_str++;
      if (fetch_valid === 1'b1) break;
    end
    if (f_lat == 10)
    begin
      n_fail++;
      complete_run();
    end
    check(fetch_data, {6'h2A, a[14:2], a[14:2]});
    @(posedge core_clk);
    fetch_req <= 1'b0;
  endtask
  task automatic t_reset;
    reg_rd(4'h0, 8'hE6);
    reg_rd(4'h1, 8'h00);
    reg_rd(4'h2, 8'h00);
    reg_rd(4'h7, 8'h00);
    reg_rd(4'h3, 8'h00);
  endtask
  task automatic t_miss_hit;
    fetch(15'h0100);
    check(32'(f_miss), 32'h1);
    check(32'(f_lat <= 5), 32'h1);
    check(32'(f_str), 32'h1);
    fetch(15'h0103);
    check(32'(f_lat), 32'h1);
    check(32'(f_miss), 32'h0);
    fetch(15'h0104);
    check(32'(f_miss), 32'h0);
  endtask
  task automatic t_strobe;
    reg_wr(4'h0, 8'hC6);
    reg_wr(4'h2, 8'h10);
    reg_wr(4'h0, 8'hE6);
    reg_rd(4'h2, 8'h10);
    fetch(15'h0200);
    check(32'(f_str), 32'h2);
    reg_wr(4'h2, 8'h00);
  endtask
  // fills blocked, then allowed; second word evicts the linear entry
  task automatic t_permit;
    reg_wr(4'h0, 8'h66);
    fetch(15'h0300);
    fetch(15'h0400);
    fetch(15'h0300);
    check(32'(f_miss), 32'h1);
    reg_wr(4'h0, 8'hE6);
    fetch(15'h0300);
    fetch(15'h0400);
    fetch(15'h0300);
    check(32'(f_miss), 32'h0);
  endtask
  task automatic t_flush;
    fetch(15'h0A00);
    reg_wr(4'h0, 8'hF6);
    reg_rd(4'h0, 8'hE6);
    fetch(15'h0A04);
    check(32'(f_miss), 32'h1);
    fetch(15'h0300);
    check(32'(f_miss), 32'h1);
  endtask
  task automatic t_mod;
    fetch(15'h0500);
    fetch(15'h0600);
    @(posedge core_clk);
    flash_mod <= 1'b1;
    flash_mod_addr <= 15'h0501;
    @(posedge core_clk);
    flash_mod <= 1'b0;
    fetch(15'h0500);
    check(32'(f_miss), 32'h1);
    @(posedge core_clk);
    flash_mod <= 1'b1;
    flash_mod_page <= 1'b1;
    flash_mod_addr <= 15'h0650;
    flash_page_mask <= 15'h7F00;
    @(posedge core_clk);
    flash_mod <= 1'b0;
    flash_mod_page <= 1'b0;
    fetch(15'h0500);
    check(32'(f_miss), 32'h0);
    fetch(15'h0600);
    check(32'(f_miss), 32'h1);
  endtask
  task automatic t_random;
    reg_wr(4'h1, 8'h08);
    reg_rd(4'h1, 8'h08);
    fetch(15'h0700);
    fetch(15'h0800);
    fetch(15'h0700);
    check(32'(f_miss), 32'h0);
    reg_wr(4'h0, 8'hC6);
    fetch(15'h0900);
    check(32'(f_miss), 32'h1);
    fetch(15'h0904);
    check(32'(f_miss), 32'h1);
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_miss_hit();
    t_strobe();
    t_permit();
    t_flush();
    t_mod();
    t_random();
    complete_run();
  end
endmodule // branch_target_cache_prefetch_tb
